// [hw/sol_strap_latch.sv]
/*
 * Strap option latch: samples the option pins while reset is held and
 * turns the latched levels into uplink pin directions and clock choices.
 * Assumes board pull resistors hold the strap pins during reset and that
 * register overrides arrive as levels on the system clock.
 */
// Function
// [R1] Sample every strap pin while reset is active; use levels as configuration.
// [R2] Strap pins are pulled inputs in reset, normal outputs afterwards.
// [R3] Type strap: 00 MII, 01 RMII, 10 GMII, 11 RGMII default.
// [R4] GMII/MII: role high gives MAC (default), low gives PHY.
// [R5] GMII PHY role drives CRS and COL as outputs.
// [R6] MII PHY role drives CRS, COL, receive and transmit clocks.
// [R7] RMII role high: internal clock mode, 50 MHz out on receive clock.
// [R8] RMII role low: partner supplies 50 MHz into transmit clock pin.
// [R9] RMII clock source also selectable through register 0x56 bit 7.
// [R10] Reference output strap high enables 25 MHz output, low disables.
// [R11] RMII normal: PLL strap high keeps crystal, low uses transmit clock.
// [R12] Speed strap high gives 1 Gbps, low 10/100; register may change it.
// [R13] Serial bus strap low selects SPI (default), high MDC/MDIO.
// [R14] Host should use SPI with RGMII for the v2.0 setting.
// [R15] Host controls configuration via SPI or MDC/MDIO in managed mode.
// [R16] Latched values hold after reset until resample or register override.
module sol_strap_latch (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [1:0] uplink_type_strap_in,
    input wire logic uplink_role_strap_in,
    input wire logic refout_enable_strap_in,
    input wire logic pll_source_strap_in,
    input wire logic uplink_speed_strap_in,
    input wire logic serial_out_bus_strap_in,
    input wire logic rmii_clk_ovr_en_in,
    input wire logic rmii_clk_ovr_internal_in,
    input wire logic speed_ovr_en_in,
    input wire logic speed_ovr_gig_in,
    output logic [1:0] uplink_type_out,
    output logic uplink_role_mac_out,
    output logic uplink_crs_col_oe_out,
    output logic uplink_rx_clock_oe_out,
    output logic uplink_tx_clock_oe_out,
    output logic rmii_clk_internal_out,
    output logic switch_clk_crystal_out,
    output logic reference_clock_out_en_out,
    output logic uplink_speed_gig_out,
    output logic mgmt_mdio_out,
    output logic strap_pins_output_mode_out
);

    sol_pkg::sol_state_t state_reg;
    sol_pkg::sol_state_t state_next;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        sol_pkg::sol_straps_t s;
        logic is_rmii;
        logic is_mii;
        logic is_gmii;
        logic rmii_int;
        s = state_reg.straps;
        is_rmii = 1'b0;
        is_mii = 1'b0;
        is_gmii = 1'b0;
        rmii_int = 1'b0;
        state_next = state_reg;
        // Strap pins come from the board, so they pass two flops first
        state_next.sync_type_a = uplink_type_strap_in;
        state_next.sync_type_b = state_reg.sync_type_a;
        state_next.sync_bits_a = {uplink_role_strap_in, refout_enable_strap_in,
                                  pll_source_strap_in, uplink_speed_strap_in,
                                  serial_out_bus_strap_in};
        state_next.sync_bits_b = state_reg.sync_bits_a;
        state_next.in_reset = 1'b0;
        // Straps only follow the pins while reset is held; the last sample
        // before release is what stays, so a late pull change is ignored
        if (!rst_n_in) begin
            s.uplink_type = state_reg.sync_type_b; // see [R1] see [R3]
            s.role_mac = state_reg.sync_bits_b[4]; // see [R4]
            s.refout_en = state_reg.sync_bits_b[3]; // see [R10]
            s.pll_crystal = state_reg.sync_bits_b[2]; // see [R11]
            s.speed_gig = state_reg.sync_bits_b[1]; // see [R12]
            s.bus_mdio = state_reg.sync_bits_b[0]; // see [R13]
            state_next.in_reset = 1'b1;
        end
        state_next.straps = s; // see [R16]
        case (s.uplink_type)
            sol_pkg::UPLINK_MII: is_mii = 1'b1;
            sol_pkg::UPLINK_RMII: is_rmii = 1'b1;
            sol_pkg::UPLINK_GMII: is_gmii = 1'b1;
            default: is_gmii = 1'b0;
        endcase
        // Register override of the RMII clock source takes precedence
        rmii_int = rmii_clk_ovr_en_in ? rmii_clk_ovr_internal_in : s.role_mac; // see [R9]
        // PHY role on GMII drives CRS/COL; on MII also both clocks
        state_next.ctrl.crs_col_oe = (is_gmii | is_mii) & ~s.role_mac; // see [R5] see [R6]
        state_next.ctrl.tx_clk_oe = is_mii & ~s.role_mac; // see [R6]
        // RMII clock mode sends 50 MHz out on the receive clock pin
        state_next.ctrl.rx_clk_oe = (is_mii & ~s.role_mac) | (is_rmii & rmii_int); // see [R6] see [R7]
        // Normal RMII times from the partner clock on the transmit pin
        state_next.ctrl.rmii_clk_internal = rmii_int; // see [R7] see [R8]
        state_next.ctrl.switch_clk_crystal = ~(is_rmii & ~rmii_int) | s.pll_crystal; // see [R11]
        state_next.ctrl.refout_en = s.refout_en; // see [R10]
        state_next.ctrl.speed_gig = speed_ovr_en_in ? speed_ovr_gig_in : s.speed_gig; // see [R12]
        // Either management bus reaches the full register set
        state_next.ctrl.mgmt_mdio = s.bus_mdio; // see [R13] see [R15]
        state_next.ctrl.strap_release = rst_n_in; // see [R2]
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset does not clear the straps: sampling during reset is the point
    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    assign uplink_type_out = state_reg.straps.uplink_type;
    assign uplink_role_mac_out = state_reg.straps.role_mac;
    assign uplink_crs_col_oe_out = state_reg.ctrl.crs_col_oe;
    assign uplink_rx_clock_oe_out = state_reg.ctrl.rx_clk_oe;
    assign uplink_tx_clock_oe_out = state_reg.ctrl.tx_clk_oe;
    assign rmii_clk_internal_out = state_reg.ctrl.rmii_clk_internal;
    assign switch_clk_crystal_out = state_reg.ctrl.switch_clk_crystal;
    assign reference_clock_out_en_out = state_reg.ctrl.refout_en;
    assign uplink_speed_gig_out = state_reg.ctrl.speed_gig;
    assign mgmt_mdio_out = state_reg.ctrl.mgmt_mdio;
    assign strap_pins_output_mode_out = state_reg.ctrl.strap_release;

endmodule // sol_strap_latch

// [hw/sol_pkg.sv]
/*
 * Constants and carrier types of the strap option latch.
 * Assumes a single 25 MHz system clock and a synchronous active-low reset.
 */
package sol_pkg;

    // ------------------------------------------------------------
    // Uplink interface type encodings
    // ------------------------------------------------------------
    localparam logic [1:0] UPLINK_MII = 2'h0;
    localparam logic [1:0] UPLINK_RMII = 2'h1;
    localparam logic [1:0] UPLINK_GMII = 2'h2;
    localparam logic [1:0] UPLINK_RGMII = 2'h3;

    // ------------------------------------------------------------
    // Reset (default) values of the latched options
    // ------------------------------------------------------------
    localparam logic [1:0] RST_UPLINK_TYPE = UPLINK_RGMII;
    localparam logic RST_ROLE_MAC = 1'h1;
    localparam logic RST_REFOUT_EN = 1'h1;
    localparam logic RST_PLL_CRYSTAL = 1'h1;
    localparam logic RST_SPEED_GIG = 1'h1;
    localparam logic RST_BUS_MDIO = 1'h0;

    // ------------------------------------------------------------
    // Register 0x56 field positions used by overrides
    // ------------------------------------------------------------
    localparam logic [7:0] CFG56_OFFSET = 8'h56;
    localparam int CFG56_RMII_CLK_BIT = 7;
    localparam int CFG56_RGMII_V2_HI = 4;
    localparam int CFG56_RGMII_V2_LO = 3;

    typedef struct packed {
        logic [1:0] uplink_type;
        logic role_mac;
        logic refout_en;
        logic pll_crystal;
        logic speed_gig;
        logic bus_mdio;
    } sol_straps_t;

    typedef struct packed {
        logic crs_col_oe;
        logic rx_clk_oe;
        logic tx_clk_oe;
        logic rmii_clk_internal;
        logic switch_clk_crystal;
        logic refout_en;
        logic speed_gig;
        logic mgmt_mdio;
        logic strap_release;
    } sol_ctrl_t;

    typedef struct packed {
        logic [1:0] sync_type_a;
        logic [1:0] sync_type_b;
        logic [4:0] sync_bits_a;
        logic [4:0] sync_bits_b;
        logic in_reset;
        sol_straps_t straps;
        sol_ctrl_t ctrl;
    } sol_state_t;

endpackage : sol_pkg

// [tb/sol_strap_latch_monitor.sv]
/* Port checker of sol_strap_latch. Assumes one clock and a sync reset. */
module sol_strap_latch_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic rmii_clk_ovr_en_in,
    input wire logic rmii_clk_ovr_internal_in,
    input wire logic [1:0] uplink_type_out,
    input wire logic uplink_role_mac_out,
    input wire logic uplink_crs_col_oe_out,
    input wire logic uplink_rx_clock_oe_out,
    input wire logic uplink_tx_clock_oe_out,
    input wire logic rmii_clk_internal_out,
    input wire logic strap_pins_output_mode_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic phy = !uplink_role_mac_out;
    wire logic mii = uplink_type_out == sol_pkg::UPLINK_MII;
    wire logic rmii = uplink_type_out == sol_pkg::UPLINK_RMII;
    default clocking @(posedge clk_in); endclocking
    // A frozen enable holds every output, so checks pause with it
    default disable iff (!rst_n_in || !clk_en_in);
    // Derived outputs load on the same edge as the straps, but still wait past release
    sequence s_up; rst_n_in[*4]; endsequence
    property p_mode_rst; disable iff (1'b0)
        !rst_n_in && clk_en_in |=> !strap_pins_output_mode_out; endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("pins not inputs");
    property p_mode_run; rst_n_in |=> strap_pins_output_mode_out; endproperty
    a_mode_run: assert property (p_mode_run) else $error("pins not outputs");
    property p_hold; s_up |-> $stable(uplink_type_out) && $stable(uplink_role_mac_out); endproperty
    a_hold: assert property (p_hold) else $error("straps moved");
    property p_crs; s_up |-> uplink_crs_col_oe_out == (!uplink_type_out[0] && phy); endproperty
    a_crs: assert property (p_crs) else $error("crs col dir");
    property p_tx; s_up |-> uplink_tx_clock_oe_out == (mii && phy); endproperty
    a_tx: assert property (p_tx) else $error("tx clock dir");
    property p_rx; s_up ##0 $stable(rmii_clk_internal_out) |->
        uplink_rx_clock_oe_out == (mii && phy || rmii && rmii_clk_internal_out); endproperty
    a_rx: assert property (p_rx) else $error("rx clock dir");
    property p_ovr; rst_n_in[*2] ##0 rmii_clk_ovr_en_in |=>
        rmii_clk_internal_out == $past(rmii_clk_ovr_internal_in); endproperty
    a_ovr: assert property (p_ovr) else $error("clock override");
    property p_strap_clk; s_up ##0 (!rmii_clk_ovr_en_in)[*2] |->
        rmii_clk_internal_out == uplink_role_mac_out; endproperty
    a_strap_clk: assert property (p_strap_clk) else $error("clock strap");
endmodule // sol_strap_latch_monitor
bind sol_strap_latch sol_strap_latch_monitor i_sol_strap_latch_monitor (.*);

// [tb/sol_strap_model.sv]
/* Board strap resistors. Assumes the latch reports when pins turn outputs. */
module sol_strap_model (
    input wire logic clk_in,
    input wire logic released_in,
    input wire logic [6:0] level_in,
    output logic [6:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] noise_reg = 7'h55;
    always @(posedge clk_in) noise_reg <= ~noise_reg;
    // Resistor levels only show while pins are inputs; later they toggle
    assign pin_out = released_in === 1'b1 ? noise_reg : level_in;
endmodule // sol_strap_model

// [tb/sol_strap_latch_tb.sv]
/* Bench of sol_strap_latch. Assumes the model and checker files compiled first. */
module sol_strap_latch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic en = 1'b1;
    logic [6:0] lv = 7'h0;
    logic [6:0] pins;
    logic [3:0] ov = 4'h0;
    logic [11:0] obs;
    logic [16:0] rnd = 17'h17c35;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    sol_strap_model i_sol_strap_model (.clk_in(clk_in), .released_in(obs[0]), .level_in(lv),
        .pin_out(pins));
    sol_strap_latch i_sol_strap_latch (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(en),
        .uplink_type_strap_in(pins[6:5]), .uplink_role_strap_in(pins[4]),
        .refout_enable_strap_in(pins[3]), .pll_source_strap_in(pins[2]),
        .uplink_speed_strap_in(pins[1]), .serial_out_bus_strap_in(pins[0]),
        .rmii_clk_ovr_en_in(ov[3]), .rmii_clk_ovr_internal_in(ov[2]),
        .speed_ovr_en_in(ov[1]), .speed_ovr_gig_in(ov[0]), .uplink_type_out(obs[11:10]),
        .uplink_role_mac_out(obs[9]), .uplink_crs_col_oe_out(obs[8]),
        .uplink_rx_clock_oe_out(obs[7]), .uplink_tx_clock_oe_out(obs[6]),
        .rmii_clk_internal_out(obs[5]), .switch_clk_crystal_out(obs[4]),
        .reference_clock_out_en_out(obs[3]), .uplink_speed_gig_out(obs[2]),
        .mgmt_mdio_out(obs[1]), .strap_pins_output_mode_out(obs[0]));
    function automatic logic [11:0] want(logic [6:0] l, logic [3:0] o);
        logic [1:0] t = l[6:5];
        logic r = l[4];
        logic i = o[3] ? o[2] : r;
        logic pm = t == sol_pkg::UPLINK_MII && !r;
        logic rm = t == sol_pkg::UPLINK_RMII;
        return {t, r, !t[0] && !r, pm || (rm && i), pm, i, !(rm && !i && !l[2]), l[3],
            o[1] ? o[0] : l[1], l[0], 1'b1};
    endfunction
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    // The host keeps SPI management whenever the uplink is strapped RGMII
    function automatic logic [6:0] host_pick(input logic [6:0] l);
        return (l[6:5] == sol_pkg::UPLINK_RGMII) ? {l[6:1], 1'b0} : l;
    endfunction
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Overrides flip after release while the model toggles the pins
    task automatic run_case(input logic [6:0] l, input logic [3:0] o);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        lv <= l;
        ov <= o;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        check("pin mode", {11'h0, obs[0]}, 12'h0);
        repeat (4) @(posedge clk_in);
        #1;
        check("latched", obs, want(l, o));
        @(posedge clk_in);
        ov <= ~o;
        repeat (3) @(posedge clk_in);
        #1;
        check("override", obs, want(l, ~o));
        // Enable low must ignore an override change
        @(posedge clk_in);
        en <= 1'b0;
        ov <= o;
        repeat (3) @(posedge clk_in);
        #1;
        check("frozen", obs, want(l, ~o));
        @(posedge clk_in);
        en <= 1'b1;
        ov <= ~o;
        @(posedge clk_in);
    endtask
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr_next(rnd);
            run_case(host_pick(k < 8 ? {k[2:0], rnd[3:0]} : rnd[6:0]), rnd[10:7]);
            $display("case %0d done", k);
        end
        test_done();
    end
endmodule // sol_strap_latch_tb
